// File: rtl/cit_map.svh
`ifndef CIT_MAP_SVH
`define CIT_MAP_SVH
`define CIT_PHASES 3'h4
`define CIT_CLK_CTRL_ADDR 8'h8E
`define CIT_CLK_CTRL_RST 8'h01
`define CIT_STRETCH_LSB 0
`define CIT_STRETCH_MSB 2
`define CIT_T0M_BIT 3
`define CIT_TMR_SLOW 4'hC
`define CIT_TMR_FAST 4'h4
`define CIT_XMOVE_BASE 4'h2
`define CIT_RD_STROBE_GAP 2'h1
`endif

// File: rtl/cit_pkg.sv
package cit_pkg;
  typedef enum logic [1:0]
  {
    CIT_PH1 = 2'b00,
    CIT_PH2 = 2'b01,
    CIT_PH3 = 2'b10,
    CIT_PH4 = 2'b11
  } cit_phase_t;
  typedef enum logic [1:0]
  {
    CIT_ST_FETCH = 2'b00,
    CIT_ST_EXEC = 2'b01,
    CIT_ST_XMOVE = 2'b10
  } cit_state_t;
endpackage

// File: rtl/cit_opcode_rom.sv
`timescale 1ns/1ps
`include "cit_map.svh"
// Combinational opcode table: byte length and base instruction cycles
module cit_opcode_rom
  import cit_pkg::*;
(
  input wire logic [7:0] opcode, // Fetched opcode
  output logic [1:0] bytes, // Instruction length in bytes
  output logic [2:0] cycles, // Instruction cycles, base for external moves
  output logic xmove, // External data move through the data pointer
  output logic xwrite // External move is a write
);
  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = opcode[7:4];
  assign lo = opcode[3:0];
  always_comb
  begin
    bytes = 2'h1;
    cycles = 3'h1;
    xmove = 1'b0;
    xwrite = 1'b0;
    if (lo[3] || lo[3:1] == 3'h3)
    begin
      // Register and indirect forms
      bytes = 2'h1;
      cycles = 3'h1;
      if (hi == 4'hA || hi == 4'h8)
      begin
        bytes = 2'h2;
        cycles = 3'h2;
      end
      if (hi == 4'hB)
      begin
        bytes = 2'h3;
        cycles = 3'h4;
      end
      if (hi == 4'hD && lo[3])
      begin
        bytes = 2'h2;
        cycles = 3'h3;
      end
      if (hi == 4'h7)
      begin
        bytes = 2'h2;
        cycles = 3'h2;
      end
    end
    else if (lo == 4'h1)
    begin
      bytes = 2'h2;
      cycles = 3'h3;
    end
    else
    begin
      case (opcode)
        8'h00, 8'hA5: begin bytes = 2'h1; cycles = 3'h1; end
        8'h02, 8'h12: begin bytes = 2'h3; cycles = 3'h4; end
        8'h22, 8'h32: begin bytes = 2'h1; cycles = 3'h4; end
        8'h10, 8'h20, 8'h30: begin bytes = 2'h3; cycles = 3'h4; end
        8'h40, 8'h50, 8'h60, 8'h70, 8'h80: begin bytes = 2'h2; cycles = 3'h3; end
        8'h73, 8'h83, 8'h93, 8'hA3: begin bytes = 2'h1; cycles = 3'h3; end
        8'h90, 8'h85, 8'h75, 8'h43, 8'h53, 8'h63: begin bytes = 2'h3; cycles = 3'h3; end
        8'hB4, 8'hB5, 8'hD5: begin bytes = 2'h3; cycles = 3'h4; end
        8'hA4, 8'h84: begin bytes = 2'h1; cycles = 3'h5; end
        8'hE0, 8'hF0:
        begin
          bytes = 2'h1;
          cycles = 3'h2;
          xmove = 1'b1;
          xwrite = opcode[4];
        end
        8'hE2, 8'hE3, 8'hF2, 8'hF3: begin bytes = 2'h1; cycles = 3'h1; end
        8'h03, 8'h13, 8'h23, 8'h33, 8'hC4, 8'hE4, 8'hF4, 8'h04, 8'h14, 8'hD4,
        8'hC3, 8'hD3, 8'hB3: begin bytes = 2'h1; cycles = 3'h1; end
        default:
        begin
          // Direct, immediate and bit forms: two bytes, two cycles
          bytes = 2'h2;
          cycles = 3'h2;
        end
      endcase
    end
  end
endmodule

// File: rtl/cit_core_timing.sv
`timescale 1ns/1ps
`include "cit_map.svh"
// What this block does
// - Every instruction cycle lasts exactly four core clocks.
// - Four phases per instruction cycle, one per clock, sequence all events.
// - Execute during next fetch; data writes land during fetch two later.
// - Sample level interrupts on the edge ending the third phase.
// - Instructions take one to five cycles, external moves excepted.
// - External data move takes two cycles plus stretch value.
// - Stretch value is the low three bits of clock control register 8Eh.
// - Stretch changes are accepted anytime and apply to later moves.
// - Timers tick every 12 clocks by default, or every 4 when chosen.
// - Opcode 00 and reserved A5 are one-byte one-cycle idle opcodes.
// - AND, OR, XOR rows 5x, 4x, 6x with documented lengths and cycles.
// - Single-byte accumulator operations finish in one cycle, except multiply A4h and divide 84h at five.
// - Code byte moves are one byte three cycles; pointer load three/three.
// - External reads E0 and writes F0 are one byte, stretch-timed.
// - Eight-bit indirect external moves are not supported.
// - Push and pop two/two; trades one cycle, direct trade two.
// - Direct-to-direct move takes three cycles, twelve clocks.
// - Carry operations one cycle; direct-bit operations two bytes two cycles.
// - Short call three cycles; long call and both exits four cycles.
// - Bit-test branches three bytes four cycles; set-and-clear clears bit; this block only times it and clears no bit.
// - Pointer jump one byte three cycles; conditional and relative jumps three.
// - Compare-branch forms three bytes four cycles; long jump four cycles.
// - Register decrement-branch two/three; direct form three/four.
// - Stretch resets to one; write zero for full speed.
// - Stretch lengthens only external data accesses and strobes.
// - Register operands use the bank picked by two status word bits.
module cit_core_timing
  import cit_pkg::*;
(
  input wire logic REF_CLK, // Core clock
  input wire logic SYS_RST, // Async reset, active high
  input wire logic CLK_EN, // Freezes all state when low
  input wire logic [7:0] OPCODE, // Opcode byte from program memory
  input wire logic OPCODE_VALID, // Opcode present at fourth phase, taken at its end
  input wire logic [1:0] PSW_BANK, // Bank select bits of status word
  input wire logic [2:0] OPERAND_REG, // Register number of register operand
  input wire logic IRQ_LEVEL, // Level-sensitive interrupt input
  input wire logic SFR_WR, // Special register write strobe
  input wire logic SFR_RD, // Special register read strobe
  input wire logic [7:0] SFR_ADDR, // Special register address
  input wire logic [7:0] SFR_WDATA, // Special register write data
  output logic [7:0] SFR_RDATA, // Special register read data
  output logic [1:0] PHASE, // Current CPU phase, 0 for first
  output logic INSTR_START, // Pulse at first phase of a new instruction
  output logic [1:0] INSTR_BYTES, // Length of instruction being executed
  output logic [3:0] INSTR_CYCLES, // Total cycles of instruction being executed
  output logic EXEC_STROBE, // Pulse: execute previous instruction
  output logic WRITE_STROBE, // Pulse: data write of instruction two back
  output logic IRQ_SAMPLED, // Interrupt level caught at end of third phase
  output logic XDATA_RD_N, // External data read strobe, active low
  output logic XDATA_WR_N, // External data write strobe, active low
  output logic [4:0] REG_ADDR, // Internal RAM address of bank register
  output logic TIMER_TICK // One-clock timer increment pulse
);
  logic [1:0] phase_q;
  logic [3:0] cyc_left_q;
  logic [7:0] clk_ctrl_q;
  logic [7:0] sfr_rdata_q;
  logic instr_start_q;
  logic [1:0] instr_bytes_q;
  logic [3:0] instr_cycles_q;
  logic exec_q;
  logic wr_q;
  logic pend_exec_q;
  logic pend_wr_q;
  logic irq_q;
  logic rd_n_q;
  logic wr_n_q;
  logic [4:0] reg_addr_q;
  logic [3:0] tmr_cnt_q;
  logic tick_q;
  logic xmove_q;
  logic xwrite_q;
  logic [1:0] rom_bytes;
  logic [2:0] rom_cycles;
  logic rom_xmove;
  logic rom_xwrite;
  logic [2:0] stretch;
  logic last_phase;
  logic instr_end;
  logic [3:0] total_cycles;
  logic [3:0] tmr_div;

  cit_opcode_rom u_rom
  (
    .opcode(OPCODE),
    .bytes(rom_bytes),
    .cycles(rom_cycles),
    .xmove(rom_xmove),
    .xwrite(rom_xwrite)
  );

  assign stretch = clk_ctrl_q[`CIT_STRETCH_MSB:`CIT_STRETCH_LSB];
  assign last_phase = (phase_q == 2'(CIT_PH4));
  assign instr_end = last_phase && (cyc_left_q <= 4'h1);
  // Stretch only for external data moves, never fetches
  assign total_cycles = rom_xmove ? (`CIT_XMOVE_BASE + {1'b0, stretch})
                                  : {1'b0, rom_cycles};
  assign tmr_div = clk_ctrl_q[`CIT_T0M_BIT] ? `CIT_TMR_FAST : `CIT_TMR_SLOW;

  // Four phases per instruction cycle
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      phase_q <= 2'h0;
    else if (CLK_EN)
      phase_q <= phase_q + 2'h1;
  end

  // Instruction cycle counting; new opcode taken at the end of the last cycle
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cyc_left_q <= 4'h0;
      instr_start_q <= 1'b0;
      instr_bytes_q <= 2'h0;
      instr_cycles_q <= 4'h0;
      xmove_q <= 1'b0;
      xwrite_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      instr_start_q <= 1'b0;
      if (instr_end && OPCODE_VALID)
      begin
        cyc_left_q <= total_cycles;
        instr_start_q <= 1'b1;
        instr_bytes_q <= rom_bytes;
        instr_cycles_q <= total_cycles;
        xmove_q <= rom_xmove;
        xwrite_q <= rom_xwrite;
      end
      else if (instr_end)
      begin
        cyc_left_q <= 4'h0;
        xmove_q <= 1'b0;
      end
      else if (last_phase)
        cyc_left_q <= cyc_left_q - 4'h1;
    end
  end

  // Pipeline: execute during the next fetch, write during the fetch after
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pend_exec_q <= 1'b0;
      pend_wr_q <= 1'b0;
      exec_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      exec_q <= 1'b0;
      wr_q <= 1'b0;
      if (instr_start_q)
      begin
        exec_q <= pend_exec_q;
        wr_q <= pend_wr_q;
        pend_wr_q <= pend_exec_q;
        pend_exec_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      irq_q <= 1'b0;
    else if (CLK_EN && phase_q == 2'(CIT_PH3))
      irq_q <= IRQ_LEVEL;
  end

  // Strobe held low from the second cycle of the move to its end
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end
    else if (CLK_EN)
    begin
      if (xmove_q && last_phase && cyc_left_q == instr_cycles_q)
      begin
        rd_n_q <= xwrite_q;
        wr_n_q <= ~xwrite_q;
      end
      else if (instr_end)
      begin
        rd_n_q <= 1'b1;
        wr_n_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      reg_addr_q <= 5'h00;
    else if (CLK_EN)
      reg_addr_q <= {PSW_BANK, OPERAND_REG};
  end

  // Clock control register, writable any time
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      clk_ctrl_q <= `CIT_CLK_CTRL_RST;
    else if (CLK_EN && SFR_WR && SFR_ADDR == `CIT_CLK_CTRL_ADDR)
      clk_ctrl_q <= {2'h0, SFR_WDATA[5:0]};
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      sfr_rdata_q <= 8'h00;
    else if (CLK_EN && SFR_RD)
      sfr_rdata_q <= (SFR_ADDR == `CIT_CLK_CTRL_ADDR) ? clk_ctrl_q : 8'h00;
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tmr_cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      tick_q <= 1'b0;
      if (tmr_cnt_q >= tmr_div - 4'h1)
      begin
        tmr_cnt_q <= 4'h0;
        tick_q <= 1'b1;
      end
      else
        tmr_cnt_q <= tmr_cnt_q + 4'h1;
    end
  end

  assign SFR_RDATA = sfr_rdata_q;
  assign PHASE = phase_q;
  assign INSTR_START = instr_start_q;
  assign INSTR_BYTES = instr_bytes_q;
  assign INSTR_CYCLES = instr_cycles_q;
  assign EXEC_STROBE = exec_q;
  assign WRITE_STROBE = wr_q;
  assign IRQ_SAMPLED = irq_q;
  assign XDATA_RD_N = rd_n_q;
  assign XDATA_WR_N = wr_n_q;
  assign REG_ADDR = reg_addr_q;
  assign TIMER_TICK = tick_q;

  phase_wrap_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (CLK_EN && phase_q == 2'h3) |=> (phase_q == 2'h0))
    else $error("phase did not wrap after fourth");
  phase_step_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN |=> (phase_q == $past(phase_q) + 2'h1))
    else $error("phase did not advance");
  start_phase_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    instr_start_q |-> (phase_q == 2'h0))
    else $error("instruction started off first phase");
  irq_sample_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (CLK_EN && phase_q == 2'h2) |=> (irq_q == $past(IRQ_LEVEL)))
    else $error("interrupt not sampled at third phase end");
  irq_hold_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (phase_q != 2'h2) |=> $stable(irq_q))
    else $error("interrupt sample changed outside third phase");
  // Stretch as seen at the loading edge; a write in that same cycle is legal
  xmove_len_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (CLK_EN && instr_end && OPCODE_VALID && (OPCODE == 8'hE0 || OPCODE == 8'hF0))
    |=> (instr_cycles_q == 4'h2 + {1'b0, $past(stretch)}))
    else $error("external move length wrong");
  cycle_range_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (instr_start_q && !xmove_q) |-> (instr_cycles_q >= 4'h1 && instr_cycles_q <= 4'h5))
    else $error("instruction cycles out of range");
  stretch_wr_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (CLK_EN && SFR_WR && SFR_ADDR == `CIT_CLK_CTRL_ADDR) |=> (stretch == $past(SFR_WDATA[2:0])))
    else $error("stretch write lost");
  write_after_exec_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    wr_q |-> pend_wr_q)
    else $error("write without earlier execute");
  move_len_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (CLK_EN && instr_end && OPCODE_VALID && OPCODE == 8'h85) |=> (instr_cycles_q == 4'h3))
    else $error("direct move length wrong");
  strobe_scope_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!rd_n_q || !wr_n_q) |-> xmove_q)
    else $error("data strobe outside external move");
  read_strobe_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !rd_n_q |-> !xwrite_q)
    else $error("read strobe during external write");
  tick_pulse_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (CLK_EN && tick_q) |=> !tick_q)
    else $error("timer tick longer than one clock");
endmodule

// File: dv/cit_xmem_model.sv
`timescale 1ns/1ps
// Slow data memory: it only sees strobe widths, so widths are what it records
module cit_xmem_model
(
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic rd_n, // Read strobe from core
  input wire logic wr_n, // Write strobe from core
  output logic [5:0] rd_len, // Clocks of last read strobe
  output logic [5:0] wr_len // Clocks of last write strobe
);
  logic [5:0] rd_cnt_q;
  logic [5:0] wr_cnt_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_cnt_q <= 6'h00;
      wr_cnt_q <= 6'h00;
      rd_len <= 6'h00;
      wr_len <= 6'h00;
    end
    else
    begin
      rd_cnt_q <= rd_n ? 6'h00 : rd_cnt_q + 6'h01;
      wr_cnt_q <= wr_n ? 6'h00 : wr_cnt_q + 6'h01;
      if (rd_n && rd_cnt_q != 6'h00)
        rd_len <= rd_cnt_q;
      if (wr_n && wr_cnt_q != 6'h00)
        wr_len <= wr_cnt_q;
    end
  end
endmodule

// File: dv/cit_core_timing_tb.sv
`timescale 1ns/1ps
module cit_core_timing_tb;
  logic REF_CLK = 0, SYS_RST = 1, CLK_EN = 1, OPCODE_VALID = 0, IRQ_LEVEL = 0;
  logic SFR_WR = 0, SFR_RD = 0, INSTR_START, EXEC_STROBE, WRITE_STROBE, IRQ_SAMPLED;
  logic XDATA_RD_N, XDATA_WR_N, TIMER_TICK, mon = 0, irq_exp = 0, start_d = 0;
  logic [7:0] OPCODE = 8'h00, SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, op;
  logic [1:0] PSW_BANK = 2'h0, PHASE, INSTR_BYTES, ph_exp = 2'h0;
  logic [2:0] OPERAND_REG = 3'h0, st = 3'h1;
  logic [3:0] INSTR_CYCLES, prev_cyc = 4'h0;
  logic [4:0] REG_ADDR, reg_exp = 5'h00;
  logic [5:0] rd_len, wr_len, e;
  int n_fail = 0, checks_done = 0, clk_cnt = 0, prev_clk = 0, n_ins = 0;
  integer seed = 32'hb08de4b5;
  bit chain = 0;

  cit_core_timing uut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .OPCODE(OPCODE), .OPCODE_VALID(OPCODE_VALID), .PSW_BANK(PSW_BANK),
    .OPERAND_REG(OPERAND_REG), .IRQ_LEVEL(IRQ_LEVEL), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .PHASE(PHASE),
    .INSTR_START(INSTR_START), .INSTR_BYTES(INSTR_BYTES), .INSTR_CYCLES(INSTR_CYCLES),
    .EXEC_STROBE(EXEC_STROBE), .WRITE_STROBE(WRITE_STROBE), .IRQ_SAMPLED(IRQ_SAMPLED),
    .XDATA_RD_N(XDATA_RD_N), .XDATA_WR_N(XDATA_WR_N), .REG_ADDR(REG_ADDR),
    .TIMER_TICK(TIMER_TICK));
  cit_xmem_model xmem (.clk(REF_CLK), .rst(SYS_RST), .rd_n(XDATA_RD_N),
    .wr_n(XDATA_WR_N), .rd_len(rd_len), .wr_len(wr_len));

  always #20 REF_CLK = ~REF_CLK;

  function automatic logic [5:0] exp_len(input logic [7:0] o, input logic [2:0] s);
    casez (o)
      8'h00, 8'hA5, 8'h46, 8'h47, 8'h56, 8'h57, 8'h66, 8'h67, 8'hE4, 8'hF4, 8'hC4,
      8'h23, 8'h33, 8'h03, 8'h13, 8'hE2, 8'hE3, 8'hF2, 8'hF3, 8'hC6, 8'hC7, 8'hD6,
      8'hD7, 8'hC3, 8'hD3, 8'hB3, 8'b010?1???, 8'b01101???, 8'b11001???:
        return 6'h11;
      8'h55, 8'h54, 8'h52, 8'h45, 8'h44, 8'h42, 8'h65, 8'h64, 8'h62, 8'hC0, 8'hD0,
      8'hC5, 8'hB0, 8'hA0, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'h72, 8'hA2, 8'h92:
        return 6'h22;
      8'h53, 8'h43, 8'h63, 8'h85, 8'h90: return 6'h33;
      8'h93, 8'h83, 8'h73: return 6'h13;
      8'h80, 8'h40, 8'h50, 8'h60, 8'h70, 8'b????0001, 8'b11011???: return 6'h23;
      8'h22, 8'h32: return 6'h14;
      8'h12, 8'h02, 8'h20, 8'h30, 8'h10, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'b10111???,
      8'hD5: return 6'h34;
      8'hE0, 8'hF0: return {2'h1, 4'h2 + {1'b0, s}};
      default: return 6'h00;
    endcase
  endfunction

  task chk(input bit ok);
    checks_done++;
    if (!ok)
    begin
      n_fail++;
      $display("BAD %0t output differs from expected", $time);
    end
  endtask

  task conclude;
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask

  task do_reset;
    mon = 0;
    SYS_RST = 1;
    chain = 0;
    n_ins = 0;
    st = 3'h1;
    cyc(4);
    SYS_RST = 0;
    cyc(1);
    mon = 1;
  endtask

  task sfr_wr(input logic [7:0] a, input logic [7:0] d);
    SFR_WR = 1;
    SFR_ADDR = a;
    SFR_WDATA = d;
    cyc(1);
    SFR_WR = 0;
  endtask

  task sfr_rd(input logic [7:0] a, input logic [7:0] x);
    SFR_RD = 1;
    SFR_ADDR = a;
    cyc(1);
    SFR_RD = 0;
    cyc(1);
    chk(SFR_RDATA === x);
  endtask

  task set_st(input logic [2:0] s);
    sfr_wr(8'h8E, {5'h00, s});
    st = s;
  endtask

  task issue(input logic [7:0] o);
    int k;
    OPCODE = o;
    OPCODE_VALID = 1;
    e = exp_len(o, st);
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end
    while (INSTR_START !== 1'b1 && k < 60);
    OPCODE_VALID = 0;
    if (k >= 60)
    begin
      n_fail++;
      conclude;
    end
    chk(INSTR_BYTES === e[5:4] && INSTR_CYCLES === e[3:0]);
    if (chain)
      chk(clk_cnt - prev_clk === 4 * prev_cyc);
    prev_clk = clk_cnt;
    prev_cyc = e[3:0];
    // Strobes are registered from the start pulse, one clock behind it
    cyc(1);
    chk(EXEC_STROBE === (n_ins > 0) && WRITE_STROBE === (n_ins > 1));
    chain = 1;
    n_ins++;
  endtask

  task wait_tick;
    int k;
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end
    while (TIMER_TICK !== 1'b1 && k < 40);
    if (k >= 40)
    begin
      n_fail++;
      conclude;
    end
  endtask

  task tick_gap(input int x);
    int t0;
    wait_tick;
    t0 = clk_cnt;
    wait_tick;
    chk(clk_cnt - t0 === x);
  endtask

  always @(posedge REF_CLK)
  begin
    clk_cnt <= clk_cnt + (CLK_EN ? 1 : 0);
    ph_exp <= CLK_EN ? PHASE + 2'h1 : PHASE;
    if (SYS_RST)
    begin
      irq_exp <= 1'b0;
      start_d <= 1'b0;
    end
    else if (CLK_EN)
    begin
      start_d <= INSTR_START;
      if (PHASE === 2'h2)
        irq_exp <= IRQ_LEVEL;
    end
    if (CLK_EN)
      reg_exp <= {PSW_BANK, OPERAND_REG};
  end

  always @(negedge REF_CLK)
  begin
    IRQ_LEVEL <= 1'($random(seed));
    PSW_BANK <= 2'($random(seed));
    OPERAND_REG <= 3'($random(seed));
    if (mon)
    begin
      chk(PHASE === ph_exp);
      chk(IRQ_SAMPLED === irq_exp);
      chk(REG_ADDR === reg_exp);
      chk((EXEC_STROBE !== 1'b1 && WRITE_STROBE !== 1'b1) || start_d === 1'b1);
    end
  end

  initial
  begin
    do_reset;
    chk(XDATA_RD_N === 1'b1 && XDATA_WR_N === 1'b1);
    sfr_rd(8'h8E, 8'h01);
    sfr_rd(8'h8F, 8'h00);
    tick_gap(12);
    // Freezes must hold phase, sampled level and bank address
    repeat (24)
    begin
      CLK_EN = 1'($random(seed));
      cyc(1);
    end
    CLK_EN = 1;
    for (int i = 0; i < 256; i++)
      if (exp_len(i[7:0], st) != 6'h00)
        issue(i[7:0]);
    for (int s = 0; s < 8; s++)
    begin
      set_st(s[2:0]);
      issue(8'hE0);
      issue(8'hF0);
      chk(rd_len === 6'(4 * s + 4));
      issue(8'h00);
      issue(8'h00);
      chk(rd_len === 6'(4 * s + 4) && wr_len === 6'(4 * s + 4));
    end
    sfr_wr(8'h8E, 8'hFF);
    st = 3'h7;
    sfr_rd(8'h8E, 8'h3F);
    chain = 0;
    tick_gap(4);
    repeat (80)
    begin
      if ($random(seed) % 4 == 0)
        set_st(3'($random(seed)));
      op = 8'($random(seed));
      if (exp_len(op, st) == 6'h00)
        op = 8'hA5;
      issue(op);
    end
    do_reset;
    sfr_rd(8'h8E, 8'h01);
    issue(8'hE0);
    issue(8'h00);
    conclude;
  end
endmodule
